// *** dst_pkg.sv ***
// Package: register map, field layout and reset values of the DMA status tracker
package dst_pkg;
  localparam int unsigned DST_DATA_W = 16;
  localparam int unsigned DST_ADDR_W = 4;
  localparam int unsigned DST_NUM_CH = 8;
  localparam int unsigned DST_CH_W = 4;
  // Register offsets (word index on the plain register port)
  localparam logic [3:0] DST_OFF_STATUS = 4'h0;
  localparam logic [3:0] DST_OFF_RECENT_ADDR = 4'h1;
  // Field positions in the controller status register
  localparam int unsigned DST_LAC_LSB = 8;
  localparam int unsigned DST_LAC_MSB = 11;
  localparam int unsigned DST_PP_LSB = 0;
  localparam int unsigned DST_PP_MSB = 7;
  // Reset values
  localparam logic [3:0] DST_LAC_RESET = 4'hF;
  localparam logic [7:0] DST_PP_RESET = 8'h00;
  localparam logic [15:0] DST_ADDR_RESET = 16'h0000;
  localparam logic [15:0] DST_UNMAPPED_READ = 16'h0000;
endpackage : dst_pkg

// *** dst_pingpong_bit.sv ***
// One channel's ping-pong selection flag
`timescale 1ns/1ps
module dst_pingpong_bit
  import dst_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Channel events
  input wire logic block_done_i,
  input wire logic pp_enable_i,
  input wire logic ch_restart_i,
  // Status
  output logic use_secondary_o
);
  // Flips after each block in ping-pong mode; a channel restart returns it to primary
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      use_secondary_o <= 1'b0;
    end else if (ch_restart_i) begin
      use_secondary_o <= 1'b0;
    end else if (block_done_i && pp_enable_i) begin
      use_secondary_o <= ~use_secondary_o;
    end
  end
endmodule // dst_pingpong_bit

// *** dst_status_tracker.sv ***
// DMA status tracker: last active channel, ping-pong flags, recent RAM address
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module dst_status_tracker
  import dst_pkg::*;
#(
  parameter int unsigned NUM_CH = DST_NUM_CH
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // DMA engine events
  input wire logic [NUM_CH-1:0] xfer_done_i,
  input wire logic [NUM_CH-1:0] block_done_i,
  input wire logic [NUM_CH-1:0] pp_enable_i,
  input wire logic [NUM_CH-1:0] ch_restart_i,
  input wire logic ram_access_i,
  input wire logic [DST_DATA_W-1:0] ram_addr_i,
  // Register port
  input wire logic [DST_ADDR_W-1:0] reg_addr_i,
  input wire logic [DST_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DST_DATA_W-1:0] reg_rdata_o,
  // Status
  output logic [DST_CH_W-1:0] last_active_channel_o,
  output logic [NUM_CH-1:0] pingpong_flags_o
);
  // The status word has room for exactly eight flags, so refuse any other count
  if (NUM_CH != DST_NUM_CH) begin : g_bad_num_ch
    $error("dst_status_tracker serves exactly eight channels");
  end

  logic [DST_CH_W-1:0] last_active_channel;
  logic [NUM_CH-1:0] pingpong_flag;
  logic [DST_DATA_W-1:0] recent_ram_address;
  logic [DST_CH_W-1:0] next_last_active_channel;
  logic [DST_DATA_W-1:0] status_word;
  logic [DST_DATA_W-1:0] next_rdata;

  // Lowest-numbered channel wins if the engine ever reports two at once
  always_comb begin
    next_last_active_channel = last_active_channel;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (xfer_done_i[i]) begin
        next_last_active_channel = DST_CH_W'(i);
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_active_channel <= DST_LAC_RESET;
    end else begin
      last_active_channel <= next_last_active_channel;
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_pp
    dst_pingpong_bit u_pp (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .block_done_i(block_done_i[g]),
      .pp_enable_i(pp_enable_i[g]),
      .ch_restart_i(ch_restart_i[g]),
      .use_secondary_o(pingpong_flag[g])
    );
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      recent_ram_address <= DST_ADDR_RESET;
    end else if (ram_access_i) begin
      recent_ram_address <= ram_addr_i;
    end
  end

  always_comb begin
    status_word = '0;
    status_word[DST_LAC_MSB:DST_LAC_LSB] = last_active_channel;
    status_word[DST_PP_MSB:DST_PP_LSB] = pingpong_flag;
  end

  // Writes are decoded nowhere: both registers are hardware-owned
  always_comb begin
    next_rdata = DST_UNMAPPED_READ;
    case (reg_addr_i)
      DST_OFF_STATUS: next_rdata = status_word;
      DST_OFF_RECENT_ADDR: next_rdata = recent_ram_address;
      default: next_rdata = DST_UNMAPPED_READ;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= '0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_active_channel_o <= DST_LAC_RESET;
      pingpong_flags_o <= DST_PP_RESET;
    end else begin
      last_active_channel_o <= last_active_channel;
      pingpong_flags_o <= pingpong_flag;
    end
  end

  logic unused_w;
  assign unused_w = reg_wr_i ^ (^reg_wdata_i);
endmodule // dst_status_tracker

// *** dst_status_tracker_chk.sv ***
// Port checker for the DMA status tracker
`timescale 1ns/1ps
module dst_status_tracker_chk
  import dst_pkg::*;
#(parameter int unsigned NUM_CH = DST_NUM_CH) (
  // Clock, reset, events
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [NUM_CH-1:0] xfer_done_i,
  input wire logic [NUM_CH-1:0] block_done_i,
  input wire logic [NUM_CH-1:0] pp_enable_i,
  input wire logic [NUM_CH-1:0] ch_restart_i,
  input wire logic ram_access_i,
  input wire logic [DST_DATA_W-1:0] ram_addr_i,
  // Register port, status
  input wire logic [DST_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [DST_DATA_W-1:0] reg_rdata_o,
  input wire logic [DST_CH_W-1:0] last_active_channel_o,
  input wire logic [NUM_CH-1:0] pingpong_flags_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_LAC_LEGAL: assert property (last_active_channel_o < 4'h8 || &last_active_channel_o)
    else $error("channel field reserved");
  AST_RST_VAL: assert property ($rose(rst_b_i) |-> &last_active_channel_o && pingpong_flags_o == '0)
    else $error("bad reset status");
  AST_LAC_LOAD: assert property ($onehot(xfer_done_i) |-> ##2
    (1 << last_active_channel_o) == $past(xfer_done_i, 2)) else $error("channel not loaded");
  AST_STAT_RD: assert property (reg_rd_i && reg_addr_i == DST_OFF_STATUS |=>
    reg_rdata_o == {4'h0, last_active_channel_o, pingpong_flags_o}) else $error("status read");
  AST_PP_TOG: assert property (block_done_i[0] && pp_enable_i[0] && !ch_restart_i[0] |=>
    ##1 pingpong_flags_o[0] != $past(pingpong_flags_o[0])) else $error("no toggle");
  AST_PP_RST: assert property (ch_restart_i[0] |-> ##2 !pingpong_flags_o[0])
    else $error("restart ignored");
  AST_ADR_RD: assert property (ram_access_i ##1 reg_rd_i && reg_addr_i == DST_OFF_RECENT_ADDR
    |=> reg_rdata_o == $past(ram_addr_i, 2)) else $error("address read");
  AST_RD_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == '0) else $error("rdata idle");
  cover property ($onehot(xfer_done_i));
  cover property (ram_access_i ##1 reg_rd_i);
  cover property (block_done_i[0] && pp_enable_i[0]);
endmodule // dst_status_tracker_chk
bind dst_status_tracker dst_status_tracker_chk #(.NUM_CH(NUM_CH)) u_chk (.*);

// *** tb_dst_status_tracker.sv ***
// Random self-checking bench for the DMA status tracker
`timescale 1ns/1ps
module tb_dst_status_tracker;
  import dst_pkg::*;
  logic core_clk_i = 0, rst_b_i = 0, ram_access_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0] xfer_done_i = '0, block_done_i = '0, pp_enable_i = '0, ch_restart_i = '0;
  logic [7:0] pingpong_flags_o, x, b, e, r, pp;
  logic [15:0] ram_addr_i = '0, reg_wdata_i = '0, reg_rdata_o, adr, a;
  logic [3:0] reg_addr_i = '0, last_active_channel_o, lac;
  int failures = 0, cmp_count = 0;
  dst_status_tracker dut (.*);
  task automatic chk(input logic [15:0] g, e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_status(input logic [11:0] g, e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t status %h exp %h", $time, g, e);
    end
  endtask
  // Reset, then read both registers at the first edges after release
  task automatic reset_and_check;
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    {lac, pp, adr} = {4'hF, 8'h00, 16'h0000};
    repeat (12) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    {reg_rd_i, reg_addr_i} <= {1'b1, DST_OFF_STATUS};
    @(posedge core_clk_i);
    reg_addr_i <= DST_OFF_RECENT_ADDR;
    #1 chk(reg_rdata_o, {4'h0, lac, pp});
    chk_status({last_active_channel_o, pingpong_flags_o}, {lac, pp});
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, adr);
  endtask
  task final_report;
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #4 core_clk_i = ~core_clk_i;
  initial begin
    #20000 failures++;
    final_report;
  end
  initial begin
    void'($urandom(73));
    for (int n = 0; n < 200; n++) begin
      // A second reset mid-run proves the all-ones channel field returns
      if (n % 100 == 0) reset_and_check;
      @(posedge core_clk_i);
      {x, b, e, r} = $urandom;
      a = 16'($urandom);
      r = r & b & x;
      {xfer_done_i, block_done_i, pp_enable_i, ch_restart_i} <= {x, b, e, r};
      // Writes land anywhere beside events and must change nothing
      {ram_access_i, reg_wr_i, reg_addr_i, ram_addr_i, reg_wdata_i} <= {a[1:0], a[5:2], a, ~a};
      for (int i = 7; i >= 0; i--) begin
        if (x[i]) lac = 4'(i);
        pp[i] = !r[i] && (pp[i] ^ (b[i] && e[i]));
      end
      if (a[1]) adr = a;
      @(posedge core_clk_i);
      {xfer_done_i, block_done_i, ch_restart_i, ram_access_i, reg_wr_i} <= '0;
      {reg_rd_i, reg_addr_i} <= {1'b1, a[6] ? 4'h7 : 4'h1};
      @(posedge core_clk_i);
      reg_addr_i <= 4'h0;
      #1 chk(reg_rdata_o, a[6] ? 16'h0000 : adr);
      @(posedge core_clk_i);
      reg_rd_i <= 0;
      #1 chk(reg_rdata_o, {4'h0, lac, pp});
      chk_status({last_active_channel_o, pingpong_flags_o}, {lac, pp});
    end
    final_report;
  end
endmodule // tb_dst_status_tracker
